// file: pkg/sensor_comp_map.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  sensor compensation filter. Assumes a 32-bit AHB-Lite register bus.
*/
`ifndef SENSOR_COMP_MAP_SVH
`define SENSOR_COMP_MAP_SVH

// ----------------------------------------------------------------------------
// register map (word indices, compared with haddr_in[6:2])
// ----------------------------------------------------------------------------
`define COEF_COUNT 30
`define ADDR_CTRL 5'd30
`define ADDR_STATUS 5'd31
`define ADDR_HI_BITS 25

// ----------------------------------------------------------------------------
// coefficient slots, one word each at byte address 4*slot
// ----------------------------------------------------------------------------
`define IDX_PRESS_GAIN 0
`define IDX_PRESS_OFFSET 1
`define IDX_TEMP_GAIN 2
`define IDX_TEMP_OFFSET 3
`define IDX_H0 4
`define IDX_G0 8
`define IDX_N0 12
`define IDX_M0 16
`define IDX_NORMAL_LOW 20
`define IDX_NORMAL_HIGH 21
`define IDX_LOW_CLAMP 22
`define IDX_HIGH_CLAMP 23
`define IDX_A0 24
`define IDX_A1 25
`define IDX_A2 26
`define IDX_B0 27
`define IDX_B1 28
`define IDX_B2 29

// ----------------------------------------------------------------------------
// output stage control fields
// ----------------------------------------------------------------------------
`define CTRL_CAP_BIT 0
`define CTRL_RATIO_BIT 1
`define CTRL_CURRENT_BIT 2
`define CTRL_GAIN_LSB 4
`define CTRL_GAIN_MSB 6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define COEF_RESET 16'h0000
`define UNITY_GAIN_RESET 16'h4000
`define NORMAL_HIGH_RESET 16'hffff
`define CTRL_RESET 7'h00
`define DAC_CODE_RESET 14'h0000
`define DAC_GAIN_FIXED 3'h0

// ----------------------------------------------------------------------------
// fixed point and timing
// ----------------------------------------------------------------------------
`define FRAC_BITS 14
`define H_SCALE_SHIFT 2
`define DAC_CODE_MAX 16'h3fff
`define SAMPLE_PERIOD_NS 128000
`define CLK_PERIOD_NS 4

`endif

// file: pkg/sensor_comp_pkg.sv
/*
  Types of the sensor compensation filter: sequencer states and the packed
  state record. Assumes sensor_comp_map.svh for the constants.
*/
`include "sensor_comp_map.svh"

package sensor_comp_pkg;

  // --------------------------------------------------------------------------
  // sequencer states, one pass per accepted sample
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GAIN,
    ST_POWERS,
    ST_POLY,
    ST_CLAMP,
    ST_FILTER
  } seq_state_e;

  // --------------------------------------------------------------------------
  // whole state of the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    seq_state_e st;
    logic [15:0] tick_cnt;
    logic [`COEF_COUNT-1:0][15:0] coef;
    logic [6:0] ctrl;
    logic [15:0] press_smp;
    logic [15:0] temp_smp;
    logic signed [63:0] p;
    logic signed [63:0] t;
    logic signed [63:0] p2;
    logic signed [63:0] p3;
    logic signed [63:0] t2;
    logic signed [63:0] t3;
    logic signed [63:0] y;
    logic [15:0] clamped;
    logic signed [31:0] w1;
    logic signed [31:0] w2;
    logic [15:0] filtered;
    logic [13:0] dac_code;
    logic [2:0] gain_out;
    logic cap_out;
    logic ratio_out;
    logic current_out;
    logic done;
    logic bus_wr;
    logic [4:0] bus_idx;
    logic [31:0] hrdata;
    logic hreadyout;
  } comp_state_s;

endpackage : sensor_comp_pkg

// file: rtl/sensor_compensation_filter.sv
/*
  Digital datapath of a bridge-sensor conditioner: gain/offset correction,
  cubic temperature and nonlinearity polynomial, clamping, second-order IIR
  filter and the 14-bit output converter code, with an AHB-Lite slave for
  coefficients and output stage control.
  Assumes: ADC codes come from decimators on the same clock, the output
  converter and analog output stage sit outside, one AHB-Lite master.
*/
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_comp_map.svh"

module sensor_compensation_filter #(
  parameter int SAMPLE_CYCLES = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // decimator codes
  input wire logic [15:0] press_adc_in,
  input wire logic [15:0] temp_adc_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // output converter and analog stage control
  output logic [13:0] dac_code_out,
  output logic out_cap_switch_en_out,
  output logic ratiometric_out,
  output logic current_mode_out,
  output logic [2:0] dac_gain_out,
  output logic sample_done_out
);

  // --------------------------------------------------------------------------
  // fixed point helpers
  // --------------------------------------------------------------------------

  // sign extension of a 16-bit coefficient or code
  function automatic logic signed [63:0] sx(input logic [15:0] v);
    sx = {{48{v[15]}}, v};
  endfunction : sx

  // product rescaled so that 2^14 is unity
  function automatic logic signed [63:0] mul_q(input logic signed [63:0] a,
                                               input logic signed [63:0] b);
    logic signed [63:0] prod;
    // product kept at 64 bits; the widest term stays well short of a wrap
    prod = a * b;
    mul_q = prod >>> `FRAC_BITS;
  endfunction : mul_q

  // cubic in temperature from four coefficient slots
  function automatic logic signed [63:0] cubic(input logic [15:0] c0,
                                               input logic [15:0] c1,
                                               input logic [15:0] c2,
                                               input logic [15:0] c3,
                                               input logic signed [63:0] t1,
                                               input logic signed [63:0] t2,
                                               input logic signed [63:0] t3);
    cubic = sx(c0) + mul_q(sx(c1), t1) + mul_q(sx(c2), t2) + mul_q(sx(c3), t3);
  endfunction : cubic

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  sensor_comp_pkg::comp_state_s s_r;
  sensor_comp_pkg::comp_state_s s_nxt;

  logic signed [63:0] hp;
  logic signed [63:0] gp;
  logic signed [63:0] np;
  logic signed [63:0] mp;
  logic signed [63:0] xin;
  logic signed [63:0] wv;
  logic signed [63:0] fv;
  logic [15:0] rd_word;
  logic addr_ok;
  logic word_ok;
  logic signed [63:0] norm_hi;
  logic signed [63:0] norm_lo;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------

  // one process computes the whole next record; the datapath is a slow
  // sequencer, so wide single-cycle multiplies are traded for simplicity
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    // temperature cubics, settled once t, t2 and t3 are stored
    hp = cubic(s_r.coef[`IDX_H0], s_r.coef[`IDX_H0+1], s_r.coef[`IDX_H0+2],
               s_r.coef[`IDX_H0+3], s_r.t, s_r.t2, s_r.t3);
    gp = cubic(s_r.coef[`IDX_G0], s_r.coef[`IDX_G0+1], s_r.coef[`IDX_G0+2],
               s_r.coef[`IDX_G0+3], s_r.t, s_r.t2, s_r.t3);
    np = cubic(s_r.coef[`IDX_N0], s_r.coef[`IDX_N0+1], s_r.coef[`IDX_N0+2],
               s_r.coef[`IDX_N0+3], s_r.t, s_r.t2, s_r.t3);
    mp = cubic(s_r.coef[`IDX_M0], s_r.coef[`IDX_M0+1], s_r.coef[`IDX_M0+2],
               s_r.coef[`IDX_M0+3], s_r.t, s_r.t2, s_r.t3);
    // filter terms are formed every cycle but only stored in the filter step
    xin = {48'h0, s_r.clamped};
    wv = (sx(s_r.coef[`IDX_A0]) * xin + sx(s_r.coef[`IDX_A1]) * 64'(s_r.w1)
          + sx(s_r.coef[`IDX_A2]) * 64'(s_r.w2)) >>> `FRAC_BITS;
    fv = (sx(s_r.coef[`IDX_B0]) * wv + sx(s_r.coef[`IDX_B1]) * 64'(s_r.w1)
          + sx(s_r.coef[`IDX_B2]) * 64'(s_r.w2)) >>> `FRAC_BITS;
    rd_word = 16'h0000;

    // bus decode; narrow writes are dropped, since every register is one word
    addr_ok = (haddr_in[31:7] == `ADDR_HI_BITS'h0) && (haddr_in[1:0] == 2'h0);
    word_ok = (hsize_in == 3'h2);

    // limits are unsigned words; widened so a negative result reads as low
    norm_hi = $signed({48'h0, s_r.coef[`IDX_NORMAL_HIGH]});
    norm_lo = $signed({48'h0, s_r.coef[`IDX_NORMAL_LOW]});

    // sample rate divider: one enable pulse per sample period
    if (s_r.tick_cnt == 16'(SAMPLE_CYCLES - 1))
    begin
      s_nxt.tick_cnt = 16'h0000;
    end
    else
    begin
      s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
    end

    // data phase write; applied before the read so back-to-back reads see it
    if (s_r.bus_wr)
    begin
      if (s_r.bus_idx == `ADDR_CTRL)
      begin
        s_nxt.ctrl = hwdata_in[6:0];
      end
      else if (s_r.bus_idx < 5'(`COEF_COUNT))
      begin
        s_nxt.coef[s_r.bus_idx] = hwdata_in[15:0];
      end
    end

    // address phase: decode, capture write target, fetch read data
    s_nxt.bus_wr = 1'b0;
    if (hsel_in && hready_in && htrans_in[1])
    begin
      s_nxt.bus_idx = haddr_in[6:2];
      s_nxt.bus_wr = hwrite_in && addr_ok && word_ok && (haddr_in[6:2] != `ADDR_STATUS);
      // status is read only; a write to it never reaches the table
      if (addr_ok && !hwrite_in)
      begin
        if (haddr_in[6:2] == `ADDR_CTRL)
        begin
          rd_word = {9'h000, s_nxt.ctrl};
        end
        else if (haddr_in[6:2] == `ADDR_STATUS)
        begin
          rd_word = s_r.filtered;
        end
        else if (haddr_in[6:2] < 5'(`COEF_COUNT))
        begin
          rd_word = s_nxt.coef[haddr_in[6:2]];
        end
      end
      s_nxt.hrdata = {16'h0000, rd_word};
    end

    // output stage controls follow the control word
    s_nxt.cap_out = s_nxt.ctrl[`CTRL_CAP_BIT];
    s_nxt.ratio_out = s_nxt.ctrl[`CTRL_RATIO_BIT];
    s_nxt.current_out = s_nxt.ctrl[`CTRL_CURRENT_BIT];
    // current loop has a fixed gain, so the field is ignored there
    s_nxt.gain_out = s_nxt.ctrl[`CTRL_CURRENT_BIT] ? `DAC_GAIN_FIXED
                     : s_nxt.ctrl[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];

    // compensation sequencer, strictly in processing order
    unique case (s_r.st)
      sensor_comp_pkg::ST_IDLE:
      begin
        if (s_r.tick_cnt == 16'(SAMPLE_CYCLES - 1))
        begin
          // both codes taken on the same edge, so they stay a pair
          s_nxt.press_smp = press_adc_in;
          s_nxt.temp_smp = temp_adc_in;
          s_nxt.st = sensor_comp_pkg::ST_GAIN;
        end
      end
      sensor_comp_pkg::ST_GAIN:
      begin
        // offset joins the code before the gain, all signed
        s_nxt.p = mul_q(sx(s_r.coef[`IDX_PRESS_GAIN]),
                        sx(s_r.press_smp) + sx(s_r.coef[`IDX_PRESS_OFFSET]));
        s_nxt.t = mul_q(sx(s_r.coef[`IDX_TEMP_GAIN]),
                        sx(s_r.temp_smp) + sx(s_r.coef[`IDX_TEMP_OFFSET]));
        s_nxt.st = sensor_comp_pkg::ST_POWERS;
      end
      sensor_comp_pkg::ST_POWERS:
      begin
        // cube built from the square in one cycle; a long path, but slow rate
        s_nxt.p2 = mul_q(s_r.p, s_r.p);
        s_nxt.p3 = mul_q(mul_q(s_r.p, s_r.p), s_r.p);
        s_nxt.t2 = mul_q(s_r.t, s_r.t);
        s_nxt.t3 = mul_q(mul_q(s_r.t, s_r.t), s_r.t);
        s_nxt.st = sensor_comp_pkg::ST_POLY;
      end
      sensor_comp_pkg::ST_POLY:
      begin
        // h scaled by four, g at 2^14 unity, kept full width until the clamp
        s_nxt.y = (hp <<< `H_SCALE_SHIFT) + mul_q(gp, s_r.p)
                  + mul_q(np, s_r.p2) + mul_q(mp, s_r.p3);
        s_nxt.st = sensor_comp_pkg::ST_CLAMP;
      end
      sensor_comp_pkg::ST_CLAMP:
      begin
        // high limit is tested first, so it wins if the limits cross
        if (s_r.y > norm_hi)
        begin
          s_nxt.clamped = s_r.coef[`IDX_HIGH_CLAMP];
        end
        else if (s_r.y < norm_lo)
        begin
          s_nxt.clamped = s_r.coef[`IDX_LOW_CLAMP];
        end
        else
        begin
          s_nxt.clamped = s_r.y[15:0];
        end
        s_nxt.st = sensor_comp_pkg::ST_FILTER;
      end
      sensor_comp_pkg::ST_FILTER:
      begin
        if (s_r.coef[`IDX_A0] == 16'h0000)
        begin
          // a zero input weight means the filter is bypassed
          s_nxt.filtered = s_r.clamped;
        end
        else if (fv < 64'sd0)
        begin
          // no converter code below zero, so a negative result is held there
          s_nxt.filtered = 16'h0000;
        end
        else if (fv > 64'sh0000_0000_0000_ffff)
        begin
          s_nxt.filtered = 16'hffff;
        end
        else
        begin
          s_nxt.filtered = fv[15:0];
        end
        // history moves only here, once per accepted sample
        s_nxt.w2 = s_r.w1;
        s_nxt.w1 = wv[31:0];
        s_nxt.done = 1'b1;
        s_nxt.st = sensor_comp_pkg::ST_IDLE;
      end
      default:
      begin
        // two of the eight codes are unused; fall back to idle, never lock up
        s_nxt.st = sensor_comp_pkg::ST_IDLE;
      end
    endcase

    // converter code is the filtered value held to 14-bit full scale
    if (s_nxt.filtered > `DAC_CODE_MAX)
    begin
      s_nxt.dac_code = 14'h3fff;
    end
    else
    begin
      s_nxt.dac_code = s_nxt.filtered[13:0];
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------

  // reset puts the converter code and filter history at zero
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
      s_r.st <= sensor_comp_pkg::ST_IDLE;
      // gains start at unity so the gain step passes codes on unchanged; the polynomial slots reset to zero
      s_r.coef[`IDX_PRESS_GAIN] <= `UNITY_GAIN_RESET;
      s_r.coef[`IDX_TEMP_GAIN] <= `UNITY_GAIN_RESET;
      s_r.coef[`IDX_NORMAL_HIGH] <= `NORMAL_HIGH_RESET;
      s_r.coef[`IDX_HIGH_CLAMP] <= `NORMAL_HIGH_RESET;
      s_r.ctrl <= `CTRL_RESET;
      s_r.dac_code <= `DAC_CODE_RESET;
      s_r.w1 <= 32'h0000_0000;
      s_r.w2 <= 32'h0000_0000;
      s_r.hreadyout <= 1'b1;
    end
    else
    begin
      // one register copy of the whole record per clock
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, straight from the state register except the constant hresp_out
  // --------------------------------------------------------------------------
  // no output passes through logic after its register
  assign hrdata_out = s_r.hrdata;
  assign hreadyout_out = s_r.hreadyout;
  assign hresp_out = 1'b0; // always okay; the bus has no error case here
  assign dac_code_out = s_r.dac_code;
  assign out_cap_switch_en_out = s_r.cap_out;
  assign ratiometric_out = s_r.ratio_out;
  assign current_mode_out = s_r.current_out;
  assign dac_gain_out = s_r.gain_out;
  assign sample_done_out = s_r.done;

endmodule : sensor_compensation_filter

`default_nettype wire

// file: verif/sensor_adc_model.sv
/*
  Decimator stand-in: hands pressure and temperature codes to the core.
  Assumes the bench sets the next codes; one core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module sensor_adc_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // codes asked for by the bench
  input wire logic [15:0] press_set_in,
  input wire logic [15:0] temp_set_in,
  // codes toward the core
  output logic [15:0] press_out,
  output logic [15:0] temp_out
);
  // registered, so a code never moves at the capture edge itself
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      press_out <= 16'h0000;
      temp_out <= 16'h0000;
    end
    else
    begin
      press_out <= press_set_in;
      temp_out <= temp_set_in;
    end
  end
endmodule : sensor_adc_model

`default_nettype wire

// file: verif/sensor_comp_assertions.sv
/*
  Port checker of the sensor compensation filter, bound into the core.
  Assumes one core clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module sensor_comp_checker #(
  parameter int SAMPLE_CYCLES = 40
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  // output stage
  input wire logic [13:0] dac_code_out,
  input wire logic out_cap_switch_en_out,
  input wire logic ratiometric_out,
  input wire logic current_mode_out,
  input wire logic [2:0] dac_gain_out,
  input wire logic sample_done_out
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic wr_r, upd_r, seen_r;
  logic [6:0] ctrl_r;
  logic [15:0] gap_r;

  // control word comes from the data phase after its address phase
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_r <= 1'b0;
      upd_r <= 1'b0;
      seen_r <= 1'b0;
      ctrl_r <= 7'h00;
      gap_r <= 16'h0000;
    end
    else
    begin
      wr_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in && haddr_in == 32'h78;
      upd_r <= wr_r;
      if (wr_r)
        ctrl_r <= hwdata_in[6:0];
      gap_r <= sample_done_out ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | sample_done_out;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_reset_code: assert property ($fell(rst_in) |-> dac_code_out == 14'h0000)
    else $error("converter code not zero after reset");
  a_code_with_done: assert property ($changed(dac_code_out) |-> sample_done_out)
    else $error("converter code moved without a finished sample");
  a_done_pulse: assert property (sample_done_out |=> !sample_done_out)
    else $error("sample done longer than one cycle");
  a_done_spacing: assert property (sample_done_out && seen_r |-> gap_r == 16'(SAMPLE_CYCLES - 1))
    else $error("samples not one period apart");
  a_cap_switch: assert property (upd_r |-> ##1 out_cap_switch_en_out == ctrl_r[0])
    else $error("capacitor switch does not follow control");
  a_ratio_ref: assert property (upd_r |-> ##1 ratiometric_out == ctrl_r[1])
    else $error("reference select does not follow control");
  a_gain_select: assert property (upd_r |-> ##1 dac_gain_out == (ctrl_r[2] ? 3'h0 : ctrl_r[6:4]))
    else $error("gain select does not follow control");
  a_gain_fixed: assert property (current_mode_out |-> dac_gain_out == 3'h0)
    else $error("gain not fixed in current mode");

  // main scenarios reached
  c_sample: cover property (sample_done_out && seen_r);
  c_ctrl: cover property (upd_r ##1 current_mode_out);
  c_reset: cover property ($fell(rst_in));
endmodule : sensor_comp_checker

bind sensor_compensation_filter sensor_comp_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .core_clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hready_in,
  .dac_code_out, .out_cap_switch_en_out, .ratiometric_out, .current_mode_out, .dac_gain_out,
  .sample_done_out);

`default_nettype wire

// file: verif/sensor_compensation_filter_tb_top.sv
/*
  Bench of the sensor compensation filter: bus tasks, scenarios, verdict.
  Assumes the decimator model and the bound checker beside the core.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sensor_comp_map.svh"

module sensor_compensation_filter_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk, rst, hsel, hwrite, rdy, hresp, done, cap, ratio, cur;
  logic [1:0] htrans;
  logic [2:0] gain;
  logic [13:0] code;
  logic [15:0] p_set, t_set, p_code, t_code;
  logic [31:0] haddr, hwdata, hrdata, q;
  int err_total, check_count;

  // short sample period keeps the run brief
  sensor_compensation_filter #(.SAMPLE_CYCLES(40)) dut (
    .core_clk_in(clk), .rst_in(rst), .press_adc_in(p_code), .temp_adc_in(t_code),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(hrdata),
    .hreadyout_out(rdy), .hresp_out(hresp), .dac_code_out(code),
    .out_cap_switch_en_out(cap), .ratiometric_out(ratio), .current_mode_out(cur),
    .dac_gain_out(gain), .sample_done_out(done));

  sensor_adc_model adc (.clk_in(clk), .rst_in(rst), .press_set_in(p_set),
    .temp_set_in(t_set), .press_out(p_code), .temp_out(t_code));

  // clock at 250 MHz
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] ad(input int i);
    return 32'(4 * i);
  endfunction : ad

  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // every wait is bounded; running out ends the run
  task wait_for(input int lim, input logic slow);
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while ((slow ? done : rdy) !== 1'b1 && k < lim);
    if (k >= lim)
    begin
      check("wait", 32'h0, 32'h1);
      results();
    end
  endtask : wait_for

  // one single word transfer; read data taken at the data phase end
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_for(20, 1'b0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_for(20, 1'b0);
    q = hrdata;
  endtask : bus

  task do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    int ri[4];
    logic [31:0] rv[4];
    ri = '{`IDX_PRESS_GAIN, `IDX_TEMP_GAIN, `IDX_NORMAL_HIGH, `IDX_A0};
    rv = '{32'h4000, 32'h4000, 32'hffff, 32'h0};
    do_reset();
    #1;
    check("code", {18'h0, code}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, ad(ri[i]), 32'h0);
      check("reset value", q, rv[i]);
    end
    $display("test reset over");
  endtask : t_reset

  task t_ctrl();
    logic [6:0] v[4];
    v = '{7'h01, 7'h02, 7'h53, 7'h24};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 32'h78, {25'h0, v[i]});
      repeat (3) @(posedge clk);
      #1;
      check("cap", cap, v[i][0]);
      check("ratio", ratio, v[i][1]);
      check("current", cur, v[i][2]);
      check("gain", gain, v[i][2] ? 3'h0 : v[i][6:4]);
    end
    bus(1'b1, 32'h80, 32'h1234);
    bus(1'b0, 32'h80, 32'h0);
    check("unmapped", q, 32'h0);
    check("resp", hresp, 32'h0);
    $display("test control over");
  endtask : t_ctrl

  // all four cubics used; a0 zero leaves the filter out
  task t_poly();
    do_reset();
    p_set <= 16'h2000;
    t_set <= 16'h0100;
    bus(1'b1, ad(`IDX_PRESS_OFFSET), 32'h0400);
    bus(1'b1, ad(`IDX_H0), 32'h0100);
    bus(1'b1, ad(`IDX_H0 + 1), 32'h4000);
    bus(1'b1, ad(`IDX_G0), 32'h2000);
    bus(1'b1, ad(`IDX_N0), 32'h4000);
    bus(1'b1, ad(`IDX_M0), 32'h4000);
    wait_for(200, 1'b1);
    check("poly", code, 32'h39a4);
    bus(1'b0, 32'h7c, 32'h0);
    check("bypass", q, 32'h39a4);
    $display("test polynomial over");
  endtask : t_poly

  // negative code, exact threshold, one above it
  task t_clamp();
    logic [15:0] pin[3];
    logic [31:0] ex[3];
    pin = '{16'hc000, 16'h1000, 16'h1001};
    ex = '{32'h0123, 32'h1000, 32'h3abc};
    do_reset();
    bus(1'b1, ad(`IDX_G0), 32'h4000);
    bus(1'b1, ad(`IDX_LOW_CLAMP), 32'h0123);
    bus(1'b1, ad(`IDX_HIGH_CLAMP), 32'h3abc);
    bus(1'b1, ad(`IDX_NORMAL_HIGH), 32'h1000);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      p_set <= pin[i];
      repeat (2) wait_for(200, 1'b1);
      check("clamp", code, ex[i]);
    end
    $display("test clamp over");
  endtask : t_clamp

  // a0 written last so history stays zero until the set is whole
  task t_filter();
    logic [31:0] ex[3];
    ex = '{32'h0a00, 32'h0f00, 32'h1b80};
    do_reset();
    p_set <= 16'h1400;
    bus(1'b1, ad(`IDX_G0), 32'h4000);
    bus(1'b1, ad(`IDX_B0), 32'h2000);
    bus(1'b1, ad(`IDX_B2), 32'h2000);
    bus(1'b1, ad(`IDX_A1), 32'h2000);
    bus(1'b1, ad(`IDX_A0), 32'h4000);
    for (int i = 0; i < 3; i++)
    begin
      wait_for(200, 1'b1);
      check("filter", code, ex[i]);
    end
    $display("test filter over");
  endtask : t_filter

  // main sequence
  initial
  begin
    err_total = 0;
    check_count = 0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    p_set = 16'h0000;
    t_set = 16'h0000;
    t_reset();
    t_ctrl();
    t_poly();
    t_clamp();
    t_filter();
    results();
  end
endmodule : sensor_compensation_filter_tb_top

`default_nettype wire
